//--- nand_seq_defs.vh
`ifndef NAND_SEQ_DEFS_VH
`define NAND_SEQ_DEFS_VH
// Commands
`define CMD_READ_MODE 8'h00
`define CMD_CACHE_SEQ 8'h31
`define CMD_CACHE_LAST 8'h3F
`define CMD_PROG_SETUP 8'h80
`define CMD_PROG_PAGE 8'h10
`define CMD_PROG_CACHE 8'h15
`define CMD_COL_CHANGE 8'h85
`define CMD_RAND_READ 8'h05
`define CMD_RAND_READ_GO 8'hE0
`define CMD_STATUS 8'h70
`define CMD_STATUS_ENH 8'h78
`define CMD_RESET 8'hFF
// Status bits
`define ST_FAIL 0
`define ST_FAILC 1
`define ST_ARRAY_READY 5
`define ST_RDY 6
// Host registers
`define REG_CTRL 4'h0
`define REG_ADDR 4'h1
`define REG_DATA 4'h2
`define REG_STATUS 4'h3
`define REG_FLASH_ST 4'h4
`define REG_PAGE 4'h5
// Ctrl opcodes (wdata[2:0])
`define OP_CACHE_SEQ 3'h1
`define OP_CACHE_RAND 3'h2
`define OP_CACHE_LAST 3'h3
`define OP_PROG_PAGE 3'h4
`define OP_PROG_CACHE 3'h5
`define OP_COL_CHANGE 3'h6
`define OP_RAND_READ 3'h7
// Bus timing in clock cycles (40 ns clock covers 30 ns cycle)
`define PULSE_CYC 2
`define ADL_NS 70
`define ADL_CYC ((`ADL_NS + 39) / 40)
`define PAGES_PER_BLOCK 64
`endif

//--- nand_pulse_gen.v
`timescale 1ns/1ps
`include "nand_seq_defs.vh"
// One strobe cycle on the flash bus: drives low strobe then releases
module nand_pulse_gen (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Request
  input wire start,
  input wire isRead,
  output wire busy,
  output reg done_ff,
  // Strobes
  output reg weN_ff,
  output reg reN_ff
);
  reg [2:0] cnt_ff;
  assign busy = (cnt_ff != 3'h0);
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 3'h0;
      weN_ff <= 1'b1;
      reN_ff <= 1'b1;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy) begin
        cnt_ff <= 3'h4;
        weN_ff <= isRead;
        reN_ff <= !isRead;
      end else if (busy) begin
        cnt_ff <= cnt_ff - 3'h1;
        if (cnt_ff == 3'h3) begin
          weN_ff <= 1'b1;
          reN_ff <= 1'b1;
        end
        if (cnt_ff == 3'h1)
          done_ff <= 1'b1;
      end
    end
  end
endmodule

//--- nand_rb_sync.v
`timescale 1ns/1ps
// Ready/busy follower: counts a short settle window before trusting high
module nand_rb_sync #(
  parameter SETTLE = 4
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Pin and arm
  input wire readyBusyN,
  input wire arm,
  output reg ready_ff
);
  reg [3:0] cnt_ff;
  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      ready_ff <= 1'b1;
    end else if (arm) begin
      cnt_ff <= SETTLE[3:0];
      ready_ff <= 1'b0;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end else begin
      ready_ff <= readyBusyN;
    end
  end
endmodule

//--- nand_cache_host.v
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "nand_seq_defs.vh"
module nand_cache_host #(
  parameter ADDR_CYCLES = 5,
  parameter DIE_BIT = 18
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Register port
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata_ff,
  // Flash bus
  output reg cleOut_ff,
  output reg aleOut_ff,
  output reg ceN_ff,
  output wire weN,
  output wire reN,
  input wire [7:0] ioIn,
  output reg [7:0] ioOut_ff,
  output reg ioOe_ff,
  input wire readyBusyN
);
  localparam S_IDLE = 4'd0;
  localparam S_CMD1 = 4'd1;
  localparam S_ADDR = 4'd2;
  localparam S_CMD2 = 4'd3;
  localparam S_WAIT = 4'd4;
  localparam S_STCMD = 4'd5;
  localparam S_STRD = 4'd6;
  localparam S_MODE = 4'd7;
  localparam S_DATA = 4'd8;
  localparam S_ADL = 4'd9;
  localparam integer ADL_INT = `ADL_CYC;

  reg [3:0] state_ff;
  reg [2:0] op_ff;
  reg [39:0] addr_ff;
  reg [2:0] acnt_ff;
  reg [2:0] aTotal_ff;
  reg [7:0] flashSt_ff;
  reg [7:0] rdByte_ff;
  reg [7:0] wrByte_ff;
  reg dataPend_ff;
  reg dataIsRead_ff;
  reg inCacheRead_ff;
  reg inCacheProg_ff;
  reg [23:0] lastRow_ff;
  reg [5:0] nextPage_ff;
  reg orderErr_ff;
  reg dieErr_ff;
  reg [1:0] adlCnt_ff;
  reg pStart;
  reg pRead;
  wire pBusy;
  wire pDone;
  wire rbReady;
  reg rbArm;

  nand_pulse_gen pulse (
    .clk(clk),
    .rst(rst),
    .start(pStart),
    .isRead(pRead),
    .busy(pBusy),
    .done_ff(pDone),
    .weN_ff(weN),
    .reN_ff(reN)
  );

  nand_rb_sync #(.SETTLE(4)) rbs (
    .clk(clk),
    .rst(rst),
    .readyBusyN(readyBusyN),
    .arm(rbArm),
    .ready_ff(rbReady)
  );

  // ------------------------------------------------------------
  // Command decode
  // ------------------------------------------------------------
  function [7:0] firstCmd;
    input [2:0] op;
    begin
      case (op)
        `OP_CACHE_SEQ: firstCmd = `CMD_CACHE_SEQ;
        `OP_CACHE_LAST: firstCmd = `CMD_CACHE_LAST;
        `OP_CACHE_RAND: firstCmd = `CMD_READ_MODE;
        `OP_COL_CHANGE: firstCmd = `CMD_COL_CHANGE;
        `OP_RAND_READ: firstCmd = `CMD_RAND_READ;
        default: firstCmd = `CMD_PROG_SETUP;
      endcase
    end
  endfunction

  function [7:0] secondCmd;
    input [2:0] op;
    begin
      case (op)
        `OP_CACHE_RAND: secondCmd = `CMD_CACHE_SEQ;
        `OP_PROG_CACHE: secondCmd = `CMD_PROG_CACHE;
        `OP_RAND_READ: secondCmd = `CMD_RAND_READ_GO;
        default: secondCmd = `CMD_PROG_PAGE;
      endcase
    end
  endfunction

  function isProgOp;
    input [2:0] op;
    begin
      isProgOp = (op == `OP_PROG_PAGE) || (op == `OP_PROG_CACHE);
    end
  endfunction

  wire fullReady = flashSt_ff[`ST_RDY] & flashSt_ff[`ST_ARRAY_READY];
  wire cacheReady = flashSt_ff[`ST_RDY] & !flashSt_ff[`ST_ARRAY_READY];
  wire [2:0] wOp = wdata[2:0];
  wire isCacheRd = (wOp == `OP_CACHE_SEQ) || (wOp == `OP_CACHE_RAND)
    || (wOp == `OP_CACHE_LAST);
  wire isProg = (wOp == `OP_PROG_PAGE) || (wOp == `OP_PROG_CACHE);
  // Gate orders by die state
  wire allowed = (state_ff == S_IDLE) && (isCacheRd ? (fullReady
    || (cacheReady && inCacheRead_ff))
    : isProg ? (fullReady || (cacheReady && inCacheProg_ff))
    : (wOp == `OP_COL_CHANGE) ? (fullReady || inCacheProg_ff)
    : (wOp == `OP_RAND_READ));
  wire take = wr && (addr == `REG_CTRL) && allowed;
  wire needAddr = (op_ff == `OP_CACHE_RAND) || isProgOp(op_ff)
    || (op_ff == `OP_COL_CHANGE) || (op_ff == `OP_RAND_READ);
  wire hasCmd2 = (op_ff == `OP_CACHE_RAND) || isProgOp(op_ff)
    || (op_ff == `OP_RAND_READ);

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    pStart = 1'b0;
    pRead = 1'b0;
    rbArm = 1'b0;
    case (state_ff)
      S_CMD1, S_ADDR, S_CMD2, S_STCMD, S_MODE: pStart = !pBusy && !pDone;
      S_STRD: begin
        pStart = !pBusy && !pDone;
        pRead = 1'b1;
      end
      S_DATA: begin
        pStart = dataPend_ff && !pBusy && !pDone;
        pRead = dataIsRead_ff;
      end
      default: pStart = 1'b0;
    endcase
    if (state_ff == S_CMD2 && pDone)
      rbArm = 1'b1;
    if (state_ff == S_CMD1 && pDone && !hasCmd2 && !needAddr)
      rbArm = 1'b1;
  end

  always @(posedge clk) begin
    if (rst) begin
      state_ff <= S_IDLE;
      op_ff <= 3'h0;
      addr_ff <= 40'h0;
      acnt_ff <= 3'h0;
      aTotal_ff <= 3'h0;
      flashSt_ff <= 8'h60;
      rdByte_ff <= 8'h00;
      wrByte_ff <= 8'h00;
      dataPend_ff <= 1'b0;
      dataIsRead_ff <= 1'b0;
      inCacheRead_ff <= 1'b0;
      inCacheProg_ff <= 1'b0;
      lastRow_ff <= 24'h0;
      nextPage_ff <= 6'h0;
      orderErr_ff <= 1'b0;
      dieErr_ff <= 1'b0;
      adlCnt_ff <= 2'h0;
      cleOut_ff <= 1'b0;
      aleOut_ff <= 1'b0;
      ceN_ff <= 1'b1;
      ioOut_ff <= 8'h00;
      ioOe_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= 32'h0;
      if (rd) begin
        case (addr)
          `REG_STATUS: rdata_ff <= {24'h0, dieErr_ff, orderErr_ff, inCacheProg_ff,
            inCacheRead_ff, dataPend_ff, rbReady, state_ff == S_DATA,
            state_ff == S_IDLE};
          `REG_FLASH_ST: rdata_ff <= {24'h0, flashSt_ff};
          `REG_DATA: rdata_ff <= {24'h0, rdByte_ff};
          `REG_PAGE: rdata_ff <= {8'h0, lastRow_ff};
          default: rdata_ff <= 32'h0;
        endcase
      end
      if (wr && addr == `REG_ADDR)
        addr_ff <= {8'h00, wdata};
      if (wr && addr == `REG_DATA && state_ff == S_DATA && !dataPend_ff) begin
        dataPend_ff <= 1'b1;
        dataIsRead_ff <= wdata[8];
        wrByte_ff <= wdata[7:0];
      end
      if (take) begin
        op_ff <= wOp;
        ceN_ff <= 1'b0;
        state_ff <= S_CMD1;
        if ((wOp == `OP_CACHE_RAND) && inCacheRead_ff
          && (addr_ff[16+DIE_BIT] != lastRow_ff[DIE_BIT]))
          dieErr_ff <= 1'b1;
        if (isProg && addr_ff[21:16] != nextPage_ff)
          orderErr_ff <= 1'b1;
      end
      case (state_ff)
        S_IDLE: begin
          cleOut_ff <= 1'b0;
          aleOut_ff <= 1'b0;
        end
        S_CMD1: begin
          cleOut_ff <= 1'b1;
          aleOut_ff <= 1'b0;
          ioOe_ff <= 1'b1;
          ioOut_ff <= firstCmd(op_ff);
          if (pDone) begin
            cleOut_ff <= 1'b0;
            acnt_ff <= 3'h0;
            aTotal_ff <= (op_ff == `OP_RAND_READ) ? 3'h2 : ADDR_CYCLES[2:0];
            if (needAddr)
              state_ff <= S_ADDR;
            else
              state_ff <= S_WAIT;
            if (op_ff == `OP_CACHE_SEQ) begin
              // Block wrap falls out of the row add
              lastRow_ff <= lastRow_ff + 24'h1;
            end
          end
        end
        S_ADDR: begin
          aleOut_ff <= 1'b1;
          ioOut_ff <= addr_ff[8*acnt_ff +: 8];
          if (pDone) begin
            acnt_ff <= acnt_ff + 3'h1;
            if (acnt_ff + 3'h1 == aTotal_ff) begin
              aleOut_ff <= 1'b0;
              if (op_ff == `OP_CACHE_RAND)
                state_ff <= S_CMD2;
              else if (op_ff == `OP_RAND_READ)
                state_ff <= S_CMD2;
              else begin
                adlCnt_ff <= ADL_INT[1:0];
                state_ff <= S_ADL;
              end
            end
          end
        end
        S_ADL: begin
          if (adlCnt_ff != 2'h0)
            adlCnt_ff <= adlCnt_ff - 2'h1;
          else
            state_ff <= S_DATA;
        end
        S_DATA: begin
          ioOe_ff <= !dataIsRead_ff;
          ioOut_ff <= wrByte_ff;
          // Sample while the read strobe is still low; the bus is gone after it
          if (dataIsRead_ff && !reN)
            rdByte_ff <= ioIn;
          if (pDone)
            dataPend_ff <= 1'b0;
          // Finish data phase with a second ctrl write
          if (wr && addr == `REG_CTRL && wdata[3] && !dataPend_ff) begin
            if (wdata[4]) begin
              op_ff <= wdata[2:0];
              state_ff <= S_CMD1;
            end else if (hasCmd2)
              state_ff <= S_CMD2;
            else begin
              ceN_ff <= 1'b1;
              state_ff <= S_IDLE;
            end
          end
        end
        S_CMD2: begin
          cleOut_ff <= 1'b1;
          ioOe_ff <= 1'b1;
          ioOut_ff <= secondCmd(op_ff);
          if (pDone) begin
            cleOut_ff <= 1'b0;
            if (op_ff == `OP_RAND_READ)
              state_ff <= S_DATA;
            else begin
              state_ff <= S_WAIT;
              if (op_ff == `OP_CACHE_RAND)
                lastRow_ff <= addr_ff[39:16];
              if (isProgOp(op_ff))
                nextPage_ff <= addr_ff[21:16] + 6'h1;
            end
          end
        end
        S_WAIT: begin
          ioOe_ff <= 1'b0;
          // Nothing is issued while busy; R/B# reporting ready starts the 78h status read
          if (rbReady)
            state_ff <= S_STCMD;
        end
        S_STCMD: begin
          cleOut_ff <= 1'b1;
          ioOe_ff <= 1'b1;
          ioOut_ff <= `CMD_STATUS_ENH;
          if (pDone) begin
            cleOut_ff <= 1'b0;
            state_ff <= S_STRD;
          end
        end
        S_STRD: begin
          ioOe_ff <= 1'b0;
          if (!reN)
            flashSt_ff <= ioIn;
          if (pDone) begin
            inCacheRead_ff <= (op_ff == `OP_CACHE_SEQ) || (op_ff == `OP_CACHE_RAND);
            inCacheProg_ff <= (op_ff == `OP_PROG_CACHE);
            // Read mode is not a legal command during cache programming
            if (isProgOp(op_ff)) begin
              ceN_ff <= 1'b1;
              state_ff <= S_IDLE;
            end else
              state_ff <= S_MODE;
          end
        end
        S_MODE: begin
          cleOut_ff <= 1'b1;
          ioOe_ff <= 1'b1;
          ioOut_ff <= `CMD_READ_MODE;
          if (pDone) begin
            cleOut_ff <= 1'b0;
            ioOe_ff <= 1'b0;
            state_ff <= S_DATA;
          end
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end
endmodule

//--- nand_host_sva.sv
`timescale 1ns/1ps
// ----
// Flash bus and register read checks
// ----
module nand_host_sva (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Watched
  input wire rd,
  input wire [31:0] rdata_ff,
  input wire cleOut_ff,
  input wire aleOut_ff,
  input wire ceN_ff,
  input wire weN,
  input wire reN,
  input wire [7:0] ioOut_ff,
  input wire ioOe_ff,
  input wire readyBusyN
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_reset_idle: assert property ($fell(rst) |-> ceN_ff && weN && reN && !ioOe_ff && !aleOut_ff)
    else $error("bus not idle after reset");
  chk_busy_cmds: assert property ($fell(weN) && cleOut_ff && !readyBusyN
    |-> ioOut_ff inside {8'h70, 8'h78, 8'hFF}) else $error("command sent while busy");
  chk_we_width: assert property ($fell(weN) |=> !weN ##1 weN)
    else $error("write strobe width wrong");
  chk_re_width: assert property ($fell(reN) |=> !reN ##1 reN)
    else $error("read strobe width wrong");
  chk_strobe_excl: assert property (weN || reN) else $error("both strobes low");
  chk_ce_framing: assert property (!weN || !reN |-> !ceN_ff) else $error("strobe without select");
  chk_no_contend: assert property (!reN |-> !ioOe_ff) else $error("host drives during read");
  chk_latch_excl: assert property (!(cleOut_ff && aleOut_ff)) else $error("cle and ale together");
  chk_bus_hold: assert property (!weN && !$past(weN) |-> $stable(ioOut_ff) && $stable(cleOut_ff))
    else $error("bus moved during strobe");
  chk_rdata_idle: assert property (!$past(rd) |-> rdata_ff == 32'h0)
    else $error("read data outside its cycle");
  chk_enh_status: assert property ($fell(weN) && cleOut_ff |-> ioOut_ff != 8'h70)
    else $error("plain status used");
  chk_wait_ready: assert property (!readyBusyN |-> reN) else $error("data read while busy");
endmodule

//--- nand_dev_model.sv
`timescale 1ns/1ps
// ----
// Flash die model
// ----
module nand_dev_model #(
  parameter BUSY = 2000
) (
  // Control
  input wire cle,
  input wire ale,
  input wire ceN,
  input wire weN,
  input wire reN,
  // Data and ready
  input wire [7:0] dIn,
  output wire [7:0] dOut,
  output wire rbN
);
  reg [7:0] mem [0:255];
  reg [15:0] col = 16'h0;
  reg [7:0] row = 8'h0;
  reg [7:0] last = 8'h0;
  reg rdy = 1'b1;
  reg array_ready = 1'b1;
  reg stOut = 1'b0;
  reg pcs = 1'b0;
  reg rnd;
  integer acnt = 0;
  integer cPg = 0;
  integer dPg = 0;
  integer badCmd = 0;
  integer i;
  time rdyAt = 0;
  time ardyAt = 0;
  wire [7:0] val = stOut ? {1'b1, rdy, array_ready, 5'h00} : col[7:0] ^ cPg[7:0];
  // Released bus shows the inverse, never a stale copy
  assign dOut = (!reN && !ceN) ? val : ~last;
  assign rbN = rdy;
  always #5 begin
    rdy = ($time >= rdyAt);
    array_ready = ($time >= ardyAt);
  end
  task busy(input integer extra);
    begin
      rdy = 1'b0;
      array_ready = 1'b0;
      rdyAt = $time + BUSY;
      ardyAt = rdyAt + extra;
    end
  endtask
  always @(posedge reN) if (!ceN) begin
    last = val;
    if (!stOut)
      col = col + 16'h1;
  end
  always @(posedge weN) if (!ceN) begin
    if (cle) begin
      if (!rdy && !(dIn inside {8'h70, 8'h78, 8'hFF})) badCmd = badCmd + 1;
      if (rdy && !array_ready && !(pcs ? dIn inside {8'h70, 8'h78, 8'hFF, 8'h80, 8'h10, 8'h15, 8'h85}
        : dIn inside {8'h70, 8'h78, 8'hFF, 8'h00, 8'h31, 8'h3F, 8'h05, 8'hE0}))
        badCmd = badCmd + 1;
      rnd = (acnt > 0);
      acnt = 0;
      stOut = (dIn == 8'h70 || dIn == 8'h78);
      case (dIn)
        8'h80: begin
          pcs = 1'b1;
          for (i = 0; i < 256; i = i + 1) mem[i] = 8'hFF;
        end
        8'h10: busy(0);
        8'h15: busy(BUSY);
        8'h31: begin
          cPg = dPg;
          dPg = rnd ? row : dPg + 1;
          col = 16'h0;
          pcs = 1'b0;
          busy(BUSY);
        end
        8'h3F: begin
          cPg = dPg;
          col = 16'h0;
          pcs = 1'b0;
          busy(0);
        end
        default: ;
      endcase
    end else if (ale) begin
      case (acnt)
        0: col[7:0] = dIn;
        1: col[15:8] = dIn;
        2: row = dIn;
        default: ;
      endcase
      acnt = acnt + 1;
    end else begin
      mem[col[7:0]] = dIn;
      col = col + 16'h1;
    end
  end
endmodule

//--- nand_cache_read_and_page_program_bench.sv
`timescale 1ns/1ps
// ----
// Bench
// ----
module nand_cache_read_and_page_program_bench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [31:0] rdata;
  wire cle, ale, ceN, weN, reN, ioOe, rbN;
  wire [7:0] ioIn, ioOut;
  integer badCount = 0, samplesChecked = 0, cycles = 0, cPg = 0, dPg = 0, col = 0;
  reg [31:0] seed = 32'h40994B4B;
  reg [31:0] v;
  reg [7:0] b0, b1;
  nand_cache_host u_nand_cache_host (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_ff(rdata), .cleOut_ff(cle), .aleOut_ff(ale), .ceN_ff(ceN),
    .weN(weN), .reN(reN), .ioIn(ioIn), .ioOut_ff(ioOut), .ioOe_ff(ioOe), .readyBusyN(rbN));
  nand_dev_model u_nand_dev_model (.cle(cle), .ale(ale), .ceN(ceN), .weN(weN), .reN(reN),
    .dIn(ioOut), .dOut(ioIn), .rbN(rbN));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      badCount = badCount + 1;
      close_out;
    end
  end
  task close_out;
    begin
      if (badCount == 0 && samplesChecked > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samplesChecked = samplesChecked + 1;
      if (got !== exp) begin
        badCount = badCount + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task rreg(input [3:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
    end
  endtask
  // Bounded poll of one status bit
  task waitSt(input integer i, input integer val);
    integer k;
    begin
      k = 0;
      rreg(4'h3, v);
      while (v[i] !== val[0] && k < 500) begin
        rreg(4'h3, v);
        k = k + 1;
      end
      chk(v[i], val);
    end
  endtask
  task stChk(input [7:0] e);
    begin
      rreg(4'h4, v);
      chk(v[7:0], e);
    end
  endtask
  // Reference page pipeline: cache gets old data page
  task ld(input integer rnd, input integer row);
    begin
      cPg = dPg;
      dPg = rnd ? row : dPg + 1;
      col = 0;
    end
  endtask
  task readN(input integer n);
    integer j;
    for (j = 0; j < n; j = j + 1) begin
      wreg(4'h2, 32'h100);
      waitSt(3, 0);
      rreg(4'h2, v);
      chk(v[7:0], (col ^ cPg) & 8'hFF);
      col = col + 1;
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wreg(4'h1, {16'd5, 16'd7});
    wreg(4'h0, 32'h2);
    waitSt(1, 1);
    ld(1, 5);
    stChk(8'hC0);
    readN(2);
    wreg(4'h0, 32'h19);
    waitSt(1, 1);
    ld(0, 0);
    readN(2);
    wreg(4'h1, 32'h3);
    wreg(4'h0, 32'h1F);
    waitSt(1, 1);
    col = 3;
    readN(1);
    wreg(4'h1, {16'd63, 16'd0});
    wreg(4'h0, 32'h1A);
    waitSt(1, 1);
    ld(1, 63);
    readN(1);
    wreg(4'h0, 32'h19);
    waitSt(1, 1);
    ld(0, 0);
    readN(1);
    wreg(4'h0, 32'h1B);
    waitSt(1, 1);
    cPg = dPg;
    col = 0;
    stChk(8'hE0);
    readN(1);
    wreg(4'h0, 32'h8);
    waitSt(0, 1);
    b0 = $random(seed);
    b1 = $random(seed);
    wreg(4'h1, {16'd9, 16'd2});
    wreg(4'h0, 32'h5);
    waitSt(1, 1);
    wreg(4'h2, {24'h0, b0});
    waitSt(3, 0);
    wreg(4'h0, 32'h8);
    waitSt(0, 1);
    stChk(8'hC0);
    wreg(4'h1, {16'd10, 16'd2});
    wreg(4'h0, 32'h4);
    waitSt(1, 1);
    wreg(4'h2, {24'h0, b1});
    waitSt(3, 0);
    wreg(4'h0, 32'h8);
    waitSt(0, 1);
    stChk(8'hE0);
    chk(u_nand_dev_model.mem[2], b1);
    chk(u_nand_dev_model.mem[3], 8'hFF);
    chk(u_nand_dev_model.badCmd, 0);
    rreg(4'h3, v);
    chk(v[7:6], 2'b01);
    close_out;
  end
endmodule
bind nand_cache_host nand_host_sva u_nand_host_sva (.clk, .rst, .rd, .rdata_ff, .cleOut_ff,
  .aleOut_ff, .ceN_ff, .weN, .reN, .ioOut_ff, .ioOe_ff, .readyBusyN);
